//--- rtl/imbd_decode.sv
// Purpose: module-bus address extension, decode, region mapping and pin handling
// Assumes: inputs synchronous to CORE_CLK_IN except pins passed through the synchroniser
// Notes:   decode outputs are combinational strobes; address and data outputs are registered
`timescale 1ns/1ps
module imbd_decode #(
    parameter int PIN_PORT_W = 8     // clock-mode, serial and converter port pins
) (
    input  wire logic        CORE_CLK_IN,
    input  wire logic        RSTN_IN,
    input  wire logic        CPU_REQ_IN,          // processor bus cycle valid
    input  wire logic [19:0] CPU_ADDR_IN,         // processor address
    input  wire logic        CPU_WRITE_IN,        // processor write
    input  wire logic [15:0] CPU_WDATA_IN,        // processor write data
    input  wire logic        MAP_WR_IN,           // write strobe to the map bit
    input  wire logic        MAP_WDATA_IN,        // value written to the map bit
    input  wire logic        RAM_CFG_WR_IN,       // write strobe to ram control
    input  wire logic        RAM_EN_WDATA_IN,     // ram enable value
    input  wire logic [12:0] RAM_BASE_WDATA_IN,   // ram base, address bits 23:11
    input  wire logic        THREE_STATE_CONTROL_IN,
    input  wire logic [15:0] DATA_PIN_IN,         // data bus pins as seen at the pad
    input  wire logic [PIN_PORT_W-1:0] PORT_PIN_IN,     // port pins
    input  wire logic [PIN_PORT_W-1:0] PORT_IS_INPUT_IN, // pin used as input port
    output logic [23:0]      BUS_ADDR_OUT,        // module bus address
    output logic [15:0]      BUS_DATA_OUT,        // module bus write data
    output logic             BUS_WRITE_OUT,       // module bus write
    output logic             MODMAP_OUT,          // map bit as a bus signal
    output logic             MOD_SEL_OUT,         // internal module selected
    output logic [15:0]      MOD_SLOT_SEL_OUT,    // one-hot module slot
    output logic             RAM_SEL_OUT,         // standby ram selected
    output logic [10:0]      RAM_OFFSET_OUT,      // offset inside ram
    output logic             EXT_SEL_OUT,         // external bus cycle
    output logic             HOLE_OUT,            // unreachable address hit
    output logic [3:0]       ADDR_PIN_OUT,        // address 23:20 test pins
    output logic [3:0]       ADDR_PIN_OE_OUT,     // enables of those pins
    output logic             BUS_PIN_OE_OUT,      // enable for all type-B drivers
    output logic [15:0]      DATA_SAMPLED_OUT,    // data pins caught just after reset release
    output logic [PIN_PORT_W-1:0] PORT_SAMPLED_OUT // synchronised port pins
);
    initial
    begin
        if (PIN_PORT_W < 1)
            $error("PIN_PORT_W must be at least one");
    end

    logic        map_r;           // module map bit
    logic        map_nxt;
    logic        map_locked_r;    // first write has been taken
    logic        map_locked_nxt;
    logic        ram_en_r;        // standby ram enable
    logic [12:0] ram_base_r;      // ram base, address bits 23:11
    logic        in_reset_r;      // high until first edge after release
    logic        in_tail_r;       // high until second edge after release
    wire         pin_catch = in_reset_r | in_tail_r; // data pin capture window
    logic [23:0] addr_r;          // registered bus address
    logic [15:0] data_r;          // registered bus data
    logic        write_r;         // registered direction
    logic        valid_r;         // registered request

    // extend processor address with copies of bit 19
    wire  [23:0] ext_addr = {{(imbd_pkg::BUS_AW - imbd_pkg::CPU_AW){CPU_ADDR_IN[imbd_pkg::SIGN_BIT]}},
                             CPU_ADDR_IN};

    // region nibble built from map bit
    wire  [3:0]  region_nib = {map_r, imbd_pkg::REGION_LOW3};

    // decode on registered address
    wire         in_hole   = (addr_r >= imbd_pkg::HOLE_LO) && (addr_r <= imbd_pkg::HOLE_HI);
    wire         in_region = (addr_r[23:20] == region_nib)
                          && (addr_r[19:12] == imbd_pkg::REGION_MID);
    wire         region_ok = (region_nib == imbd_pkg::REGION_LIVE);
    wire  [3:0]  slot_idx  = addr_r[11:8];
    wire         slot_real = imbd_pkg::MOD_PRESENT[slot_idx];
    wire         mod_hit   = valid_r && !in_hole && in_region && region_ok && slot_real;
    wire         ram_hit   = valid_r && !in_hole && ram_en_r && !mod_hit
                          && (addr_r[23:11] == ram_base_r);
    // anything reachable that is not taken inside goes off-chip
    wire         ext_hit   = valid_r && !in_hole && !mod_hit && !ram_hit;

    // first write to the map bit wins, later ones ignored
    always_comb
    begin
        map_nxt        = map_r;
        map_locked_nxt = map_locked_r;
        if (MAP_WR_IN && !map_locked_r)
        begin
            map_nxt        = MAP_WDATA_IN;
            map_locked_nxt = 1'b1;
        end
    end

    // map bit and lock
    always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            map_r        <= imbd_pkg::MAP_RESET;
            map_locked_r <= 1'b0;
        end
        else
        begin
            map_r        <= map_nxt;
            map_locked_r <= map_locked_nxt;
        end
    end

    // ram control block
    always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            ram_en_r   <= imbd_pkg::RAM_EN_RESET;
            ram_base_r <= 13'h0000;
        end
        else if (RAM_CFG_WR_IN)
        begin
            ram_en_r   <= RAM_EN_WDATA_IN;
            ram_base_r <= RAM_BASE_WDATA_IN;
        end
    end

    // reset-window flags for data pin capture: two edges after release
    // so the pad value reaches the second synchroniser stage before freezing
    always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            in_reset_r <= 1'b1;
            in_tail_r  <= 1'b1;
        end
        else
        begin
            in_reset_r <= 1'b0;
            in_tail_r  <= in_reset_r;
        end
    end

    // bus request register: full 16 data bits
    always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            addr_r  <= 24'h00_0000;
            data_r  <= 16'h0000;
            write_r <= 1'b0;
            valid_r <= 1'b0;
        end
        else
        begin
            valid_r <= CPU_REQ_IN;
            if (CPU_REQ_IN)
            begin
                addr_r  <= ext_addr;
                data_r  <= CPU_WDATA_IN;
                write_r <= CPU_WRITE_IN;
            end
        end
    end

    // data pins sampled only on the first two edges after reset release
    imbd_sync #(
        .WIDTH (imbd_pkg::DATA_W)
    ) u_data_sync (
        .clk_in  (CORE_CLK_IN),
        .rstn_in (RSTN_IN),
        .d_in    (DATA_PIN_IN),
        .en_in   ({imbd_pkg::DATA_W{pin_catch}}),
        .q_out   (DATA_SAMPLED_OUT)
    );

    // port pins sampled only when used as inputs
    imbd_sync #(
        .WIDTH (PIN_PORT_W)
    ) u_port_sync (
        .clk_in  (CORE_CLK_IN),
        .rstn_in (RSTN_IN),
        .d_in    (PORT_PIN_IN),
        .en_in   (PORT_IS_INPUT_IN),
        .q_out   (PORT_SAMPLED_OUT)
    );

    // outputs
    assign BUS_ADDR_OUT     = addr_r;
    assign BUS_DATA_OUT     = data_r;
    assign BUS_WRITE_OUT    = write_r;
    assign MODMAP_OUT       = map_r;
    assign MOD_SEL_OUT      = mod_hit;
    assign MOD_SLOT_SEL_OUT = mod_hit ? (16'h0001 << slot_idx) : 16'h0000;
    assign RAM_SEL_OUT      = ram_hit;
    assign RAM_OFFSET_OUT   = addr_r[imbd_pkg::RAM_SPAN_W-1:0];
    assign EXT_SEL_OUT      = ext_hit;
    assign HOLE_OUT         = valid_r && in_hole;
    assign ADDR_PIN_OUT     = addr_r[23:20];
    assign ADDR_PIN_OE_OUT  = 4'hF;           // type-A, always driven
    assign BUS_PIN_OE_OUT   = !THREE_STATE_CONTROL_IN;
endmodule : imbd_decode

//--- include/imbd_pkg.sv
// Purpose: shared constants for the module-bus address decoder
// Assumes: 20-bit processor addresses extended onto a 24-bit module bus
// Notes:   address windows and bus widths of the decoder live here; PIN_PORT_W and the pin capture window are set in imbd_decode
package imbd_pkg;
    localparam int          BUS_AW        = 24;            // module bus address lines
    localparam int          CPU_AW        = 20;            // processor address lines
    localparam int          DATA_W        = 16;            // module bus data lines
    localparam int          SIGN_BIT      = 19;            // processor address msb
    localparam logic [23:0] HOLE_LO       = 24'h08_0000;   // first unreachable address
    localparam logic [23:0] HOLE_HI       = 24'hF7_FFFF;   // last unreachable address
    localparam logic [2:0]  REGION_LOW3   = 3'h7;          // low three bits of the region nibble
    localparam logic [3:0]  REGION_LIVE   = 4'hF;          // nibble at which modules answer
    localparam int          REGION_SPAN_W = 12;            // module region is 4 kbyte
    localparam logic [7:0]  REGION_MID    = 8'hFF;         // bits 19:12 of the module region
    localparam int          RAM_SPAN_W    = 11;            // standby ram is 2 kbyte
    localparam int          MOD_SLOTS     = 16;            // module slots in the region
    localparam logic [15:0] MOD_PRESENT   = 16'h00FF;      // slots holding a real module
    localparam logic        MAP_RESET     = 1'b1;          // map bit value after reset
    localparam logic        RAM_EN_RESET  = 1'b0;          // ram enable after reset
endpackage : imbd_pkg

//--- rtl/imbd_sync.sv
// Purpose: two-stage synchroniser, gated per bit by a capture enable
// Assumes: one clock, asynchronous active-low reset
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module imbd_sync #(
    parameter int WIDTH = 16
) (
    input  wire logic             clk_in,
    input  wire logic             rstn_in,
    input  wire logic [WIDTH-1:0] d_in,
    input  wire logic [WIDTH-1:0] en_in,
    output logic      [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta_r;   // first stage
    logic [WIDTH-1:0] hold_r;   // second stage

    // per bit: sample only while enabled, hold otherwise
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            always_ff @(posedge clk_in or negedge rstn_in)
            begin
                if (!rstn_in)
                begin
                    meta_r[i] <= 1'b0;
                    hold_r[i] <= 1'b0;
                end
                else if (en_in[i])
                begin
                    meta_r[i] <= d_in[i];
                    hold_r[i] <= meta_r[i];
                end
            end
        end
    endgenerate

    assign q_out = hold_r;
endmodule : imbd_sync

//--- verif/imbd_chk_sva.sv
// Purpose: port-level checks of the module-bus decoder
// Assumes: one clock, asynchronous active-low reset
// Notes:   attached to every decoder instance by bind
`timescale 1ns/1ps
module imbd_chk (
    input wire logic        CORE_CLK_IN,
    input wire logic        RSTN_IN,
    input wire logic        CPU_REQ_IN,
    input wire logic [19:0] CPU_ADDR_IN,
    input wire logic        MAP_WR_IN,
    input wire logic        THREE_STATE_CONTROL_IN,
    input wire logic [23:0] BUS_ADDR_OUT,
    input wire logic        MODMAP_OUT,
    input wire logic        MOD_SEL_OUT,
    input wire logic        RAM_SEL_OUT,
    input wire logic        EXT_SEL_OUT,
    input wire logic        HOLE_OUT,
    input wire logic [3:0]  ADDR_PIN_OUT,
    input wire logic        BUS_PIN_OE_OUT
);
    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (!RSTN_IN);
    logic wr_seen_r;  // a map write was taken since reset
    wire  any_sel = MOD_SEL_OUT | RAM_SEL_OUT | EXT_SEL_OUT;  // someone answers
    // remember the first map write
    always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN)
        if (!RSTN_IN)
            wr_seen_r <= 1'b0;
        else if (MAP_WR_IN)
            wr_seen_r <= 1'b1;
    sequence req_s;
        CPU_REQ_IN;
    endsequence
    ext_copy_a:  assert property (BUS_ADDR_OUT[23:20] == {4{BUS_ADDR_OUT[19]}}) else $error("upper bits differ");
    addr_take_a: assert property (req_s |=> BUS_ADDR_OUT[19:0] == $past(CPU_ADDR_IN)) else $error("addr not taken");
    hole_quiet_a: assert property (any_sel |-> (BUS_ADDR_OUT < imbd_pkg::HOLE_LO || BUS_ADDR_OUT > imbd_pkg::HOLE_HI))
        else $error("answer in hole");
    one_answer_a: assert property (req_s |=> $onehot({any_sel, HOLE_OUT}) && $onehot0({MOD_SEL_OUT, RAM_SEL_OUT, EXT_SEL_OUT}))
        else $error("not one answer");
    mod_region_a: assert property (MOD_SEL_OUT |-> BUS_ADDR_OUT[23:20] == imbd_pkg::REGION_LIVE && MODMAP_OUT)
        else $error("module outside region");
    map_lock_a:  assert property (MAP_WR_IN && wr_seen_r |=> $stable(MODMAP_OUT)) else $error("late map write");
    pin_copy_a:  assert property (ADDR_PIN_OUT == BUS_ADDR_OUT[23:20]) else $error("addr pins differ");
    oe_float_a:  assert property (BUS_PIN_OE_OUT == !THREE_STATE_CONTROL_IN) else $error("oe wrong");
    map_reset_a: assert property ($rose(RSTN_IN) |-> MODMAP_OUT) else $error("map bit clear after reset");
endmodule : imbd_chk
bind imbd_decode imbd_chk u_chk (.CORE_CLK_IN, .RSTN_IN, .CPU_REQ_IN, .CPU_ADDR_IN, .MAP_WR_IN,
    .THREE_STATE_CONTROL_IN, .BUS_ADDR_OUT, .MODMAP_OUT, .MOD_SEL_OUT, .RAM_SEL_OUT, .EXT_SEL_OUT,
    .HOLE_OUT, .ADDR_PIN_OUT, .BUS_PIN_OE_OUT);

//--- verif/imbd_far.sv
// Purpose: far side of the module bus, reports who answered
// Assumes: selects are one-cycle strobes
// Notes:   0 none, 1 module, 2 ram, 3 external bus
`timescale 1ns/1ps
module imbd_far (
    input  wire logic       mod_sel_in,
    input  wire logic       ram_sel_in,
    input  wire logic       ext_sel_in,
    output logic      [1:0] who_out
);
    // external bus takes what no on-chip party claims
    assign who_out = mod_sel_in ? 2'h1 : ram_sel_in ? 2'h2 : ext_sel_in ? 2'h3 : 2'h0;
endmodule : imbd_far

//--- verif/imbd_address_map_decode_tb.sv
// Purpose: directed bench of the module-bus decoder
// Assumes: 100 MHz clock, reset held 12 cycles
// Notes:   selects are sampled in the cycle after the request
`timescale 1ns/1ps
`define CHK(n,e,g) begin checks_done++; if ((e) !== (g)) begin n_errors++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module imbd_address_map_decode_tb;
    logic clk = 0, rstn = 0, req = 0, wr = 1, map_wr = 0, map_d = 0, ram_wr = 0, ram_en = 0, three_state_control = 0;
    logic [19:0] addr = '0;
    logic [15:0] wd = '0, dpin = 16'h5A3C, bus_d, slot, data_q;
    logic [12:0] base = '0;
    logic [7:0]  pin = '0, pin_en = '0, port_q;
    logic [23:0] bus_addr;
    logic [10:0] ram_off;
    logic [3:0]  apin, apin_oe;
    logic [1:0]  who;
    logic        bus_wr, modmap, mod_sel, ram_sel, ext_sel, hole, pin_oe;
    int          n_errors = 0, checks_done = 0;
    imbd_decode dut (.CORE_CLK_IN(clk), .RSTN_IN(rstn), .CPU_REQ_IN(req), .CPU_ADDR_IN(addr), .CPU_WRITE_IN(wr),
        .CPU_WDATA_IN(wd), .MAP_WR_IN(map_wr), .MAP_WDATA_IN(map_d), .RAM_CFG_WR_IN(ram_wr),
        .RAM_EN_WDATA_IN(ram_en), .RAM_BASE_WDATA_IN(base), .THREE_STATE_CONTROL_IN(three_state_control), .DATA_PIN_IN(dpin),
        .PORT_PIN_IN(pin), .PORT_IS_INPUT_IN(pin_en), .BUS_ADDR_OUT(bus_addr), .BUS_DATA_OUT(bus_d),
        .BUS_WRITE_OUT(bus_wr), .MODMAP_OUT(modmap), .MOD_SEL_OUT(mod_sel), .MOD_SLOT_SEL_OUT(slot),
        .RAM_SEL_OUT(ram_sel), .RAM_OFFSET_OUT(ram_off), .EXT_SEL_OUT(ext_sel), .HOLE_OUT(hole),
        .ADDR_PIN_OUT(apin), .ADDR_PIN_OE_OUT(apin_oe), .BUS_PIN_OE_OUT(pin_oe), .DATA_SAMPLED_OUT(data_q),
        .PORT_SAMPLED_OUT(port_q));
    imbd_far far (.mod_sel_in(mod_sel), .ram_sel_in(ram_sel), .ext_sel_in(ext_sel), .who_out(who));
    // free-running core clock
    initial
    begin
        forever #5 clk = ~clk;
    end
    task automatic end_of_test;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    task automatic do_reset;
        @(posedge clk);
        rstn <= 1'b0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
    endtask : do_reset
    // one request, then judge address, data and selects
    task automatic do_req(input logic [19:0] a, input logic [3:0] es);
        @(posedge clk);
        req  <= 1'b1;
        addr <= a;
        wd   <= ~a[15:0];
        wr   <= a[0];
        @(posedge clk);
        req  <= 1'b0;
        #1;
        `CHK("bus_addr", {{4{a[19]}}, a}, bus_addr)
        `CHK("selects", es, {mod_sel, ram_sel, ext_sel, hole})
        `CHK("addr_pins", {4{a[19]}}, apin)
        `CHK("bus_data", ~a[15:0], bus_d)
        `CHK("bus_write", a[0], bus_wr)
        `CHK("addr_pin_oe", 4'hF, apin_oe)
    endtask : do_req
    task automatic t_decode;
        do_req(20'hFF000, 4'b1000);
        `CHK("slot", 16'h0001, slot)
        `CHK("far_who", 2'h1, who)
        `CHK("data_q", 16'h5A3C, data_q)
        do_req(20'hFF800, 4'b0010);
        do_req(20'h01234, 4'b0010);
        do_req(20'h7FFFF, 4'b0010);
        do_req(20'h80000, 4'b0010);
        $display("test decode done");
    endtask : t_decode
    task automatic t_ram;
        @(posedge clk);
        ram_wr <= 1'b1;
        ram_en <= 1'b1;
        base   <= 13'h0002;
        @(posedge clk);
        ram_wr <= 1'b0;
        do_req(20'h01234, 4'b0100);
        `CHK("ram_off", 11'h234, ram_off)
        do_req(20'h00FFF, 4'b0010);
        do_req(20'h017FF, 4'b0100);
        `CHK("ram_off", 11'h7FF, ram_off)
        $display("test ram done");
    endtask : t_ram
    task automatic t_map;
        @(posedge clk);
        map_wr <= 1'b1;
        map_d  <= 1'b0;
        @(posedge clk);
        map_d  <= 1'b1;
        @(posedge clk);
        map_wr <= 1'b0;
        #1;
        `CHK("modmap", 1'b0, modmap)
        do_req(20'hFF000, 4'b0010);
        do_reset();
        #1;
        `CHK("modmap", 1'b1, modmap)
        do_req(20'hFF100, 4'b1000);
        do_req(20'h01234, 4'b0010);
        $display("test map done");
    endtask : t_map
    task automatic t_pins;
        @(posedge clk);
        three_state_control    <= 1'b1;
        pin_en <= 8'hFF;
        pin    <= 8'hA5;
        dpin   <= 16'h1234;
        #1;
        `CHK("pin_oe", 1'b0, pin_oe)
        @(posedge clk);
        three_state_control <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        `CHK("pin_oe", 1'b1, pin_oe)
        `CHK("port_q", 8'hA5, port_q)
        `CHK("data_q", 16'h5A3C, data_q)
        $display("test pins done");
    endtask : t_pins
    // watchdog cuts a hang short
    initial
    begin
        repeat (5000) @(posedge clk);
        n_errors++;
        end_of_test();
    end
    initial
    begin
        do_reset();
        t_decode();
        t_ram();
        t_map();
        t_pins();
        end_of_test();
    end
endmodule : imbd_address_map_decode_tb
